// file: hw/ubrk_pkg.sv
/*
 package for the two-channel breakpoint comparator: widths, field layouts,
 cycle-type encodings and reset values. assumes nothing of its surroundings.
*/
package ubrk_pkg;
   localparam int ADDR_W  = 32;
   localparam int DATA_W  = 32;
   localparam int ADDRESS_SPACE_ID_W  = 8;
   localparam int COUNT_W = 12;

   // cycle select fields, one set per channel
   typedef enum logic [1:0] {UBRK_ID_NONE, UBRK_ID_FETCH, UBRK_ID_DATA, UBRK_ID_BOTH} ubrk_ida_t;
   typedef enum logic [1:0] {UBRK_RW_NONE, UBRK_RW_READ, UBRK_RW_WRITE, UBRK_RW_BOTH} ubrk_rw_t;
   typedef enum logic [1:0] {UBRK_SZ_ANY, UBRK_SZ_BYTE, UBRK_SZ_WORD, UBRK_SZ_LONG} ubrk_sz_t;

   typedef struct packed {
      logic      dma_not_cpu;
      ubrk_ida_t ida;
      ubrk_rw_t  rw;
      ubrk_sz_t  size;
   } ubrk_cycle_t;

   // one observed bus cycle
   typedef struct packed {
      logic              valid;
      logic              from_dma;
      logic              fetch;
      logic              write;
      ubrk_sz_t          size;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [ADDRESS_SPACE_ID_W-1:0] address_space_id;
   } ubrk_bus_t;

   localparam logic [COUNT_W-1:0] COUNT_RESET = 12'h000;
   localparam logic [COUNT_W-1:0] COUNT_ONE   = 12'h001;
   localparam logic [1:0]         LONG_LSBS   = 2'h3;
   localparam logic [1:0]         WORD_LSBS   = 2'h1;
   localparam int                 HALF_W      = 16;
endpackage : ubrk_pkg

// file: hw/ubrk_chan_if.sv
/*
 interface carrying one channel's settings between top and comparator.
 assumes settings are held stable by the top.
*/
`timescale 1ns/1ps
interface ubrk_chan_if;
   import ubrk_pkg::*;
   logic [ADDR_W-1:0] cmp_addr;
   logic [ADDR_W-1:0] addr_mask;
   ubrk_cycle_t       cyc;
   logic [DATA_W-1:0] cmp_data;
   logic [DATA_W-1:0] data_mask;
   logic              data_en;
   logic [ADDRESS_SPACE_ID_W-1:0] space_id;
   logic              address_space_id_en;
   modport top (output cmp_addr, addr_mask, cyc, cmp_data, data_mask, data_en,
                space_id, address_space_id_en);
   modport cmp (input cmp_addr, addr_mask, cyc, cmp_data, data_mask, data_en,
                space_id, address_space_id_en);
endinterface : ubrk_chan_if

// file: hw/ubrk_chan_cmp.sv
/*
 one breakpoint channel comparator, purely combinational.
 assumes the bus cycle descriptor is valid for one clock per cycle.
*/
`timescale 1ns/1ps
module ubrk_chan_cmp (
   ubrk_chan_if.cmp          cfg,
   input  ubrk_pkg::ubrk_bus_t bus,
   output logic              hit
);
   import ubrk_pkg::*;
   logic [ADDR_W-1:0] ign;
   logic              addr_ok;
   logic              type_ok;
   logic              dir_ok;
   logic              size_ok;
   logic              data_ok;
   logic              address_space_id_ok;
   logic              legal;
   logic [DATA_W-1:0] dsel;
   logic [DATA_W-1:0] msel;

   always_comb begin
      ign = cfg.addr_mask;
      if (bus.size == UBRK_SZ_LONG) begin
         ign[1:0] = ign[1:0] | LONG_LSBS;
      end else if (bus.size == UBRK_SZ_WORD && !bus.fetch) begin
         ign[0] = 1'b1;
      end
      addr_ok = ((bus.addr ^ cfg.cmp_addr) & ~ign) == '0;
      unique case (cfg.cyc.ida)
         UBRK_ID_NONE:  type_ok = 1'b0;
         UBRK_ID_FETCH: type_ok = bus.fetch;
         UBRK_ID_DATA:  type_ok = !bus.fetch;
         UBRK_ID_BOTH:  type_ok = 1'b1;
      endcase
      unique case (cfg.cyc.rw)
         UBRK_RW_NONE:  dir_ok = 1'b0;
         UBRK_RW_READ:  dir_ok = !bus.write;
         UBRK_RW_WRITE: dir_ok = bus.write;
         UBRK_RW_BOTH:  dir_ok = 1'b1;
      endcase
      size_ok = (cfg.cyc.size == UBRK_SZ_ANY) || (cfg.cyc.size == bus.size);
      // byte/word data sits in the low half; upper half ignored there
      dsel = bus.data;
      msel = cfg.data_mask;
      if (bus.size != UBRK_SZ_LONG) begin
         msel[DATA_W-1:HALF_W] = '1;
      end
      data_ok = !cfg.data_en || bus.fetch || (((dsel ^ cfg.cmp_data) & ~msel) == '0);
      address_space_id_ok = !cfg.address_space_id_en || (bus.address_space_id == cfg.space_id);
      // fetches are even-addressed reads; dma does no fetches
      legal = !(bus.fetch && (bus.write || bus.addr[0] || cfg.cmp_addr[0]))
              && !(bus.from_dma && bus.fetch)
              && (bus.from_dma == cfg.cyc.dma_not_cpu);
      hit = bus.valid && legal && addr_ok && type_ok && dir_ok && size_ok
            && data_ok && address_space_id_ok;
   end
endmodule : ubrk_chan_cmp

// file: hw/ubrk_top.sv
/*
 two-channel user breakpoint comparator: channel settings, sequencing,
 execution counting and break request with exception ordering.
 assumes the pipeline presents one cpu cycle and one dma cycle per clock at
 most, in bus order, and marks the memory-access stage of a settings write.
*/
`timescale 1ns/1ps
module ubrk_top (
   input  wire logic                          sys_clk,
   input  wire logic                          reset_n,
   // settings write, presented at the memory-access stage
   input  wire logic                          cfg_write,
   input  wire logic                          cfg_from_cpu,
   input  wire logic [ubrk_pkg::ADDR_W-1:0]   chan_a_compare_address,
   input  wire logic [ubrk_pkg::ADDR_W-1:0]   chan_a_address_mask,
   input  ubrk_pkg::ubrk_cycle_t              chan_a_cycle_select,
   input  wire logic [ubrk_pkg::ADDRESS_SPACE_ID_W-1:0]   chan_a_space_id,
   input  wire logic [ubrk_pkg::ADDR_W-1:0]   chan_b_compare_address,
   input  wire logic [ubrk_pkg::ADDR_W-1:0]   chan_b_address_mask,
   input  ubrk_pkg::ubrk_cycle_t              chan_b_cycle_select,
   input  wire logic [ubrk_pkg::DATA_W-1:0]   chan_b_compare_data,
   input  wire logic [ubrk_pkg::DATA_W-1:0]   chan_b_data_mask,
   input  wire logic                          chan_b_data_enable,
   input  wire logic [ubrk_pkg::ADDRESS_SPACE_ID_W-1:0]   chan_b_space_id,
   input  wire logic                          address_space_id_check_enable,
   input  wire logic                          sequential_mode_bit,
   input  wire logic                          chan_a_after_exec_select,
   input  wire logic                          chan_b_after_exec_select,
   input  wire logic                          count_enable,
   input  wire logic [ubrk_pkg::COUNT_W-1:0]  execution_count_target,
   input  wire logic                          flag_clear,
   // observed bus cycles
   input  ubrk_pkg::ubrk_bus_t                cpu_bus,
   input  ubrk_pkg::ubrk_bus_t                dma_bus,
   // instruction boundary and exception inputs from the pipeline
   input  wire logic                          insn_retire,
   input  wire logic                          fetch_exception,
   input  wire logic                          operand_exception,
   // outputs
   output logic                               break_pre,
   output logic                               break_post,
   output logic                               take_fetch_exc,
   output logic                               take_operand_exc,
   output logic                               chan_a_match_flag,
   output logic                               chan_b_match_flag,
   output logic [ubrk_pkg::COUNT_W-1:0]       count_remaining
);
   import ubrk_pkg::*;

   typedef struct packed {
      logic [ADDR_W-1:0]  a_addr;
      logic [ADDR_W-1:0]  a_mask;
      ubrk_cycle_t        a_cyc;
      logic [ADDRESS_SPACE_ID_W-1:0]  a_address_space_id;
      logic [ADDR_W-1:0]  b_addr;
      logic [ADDR_W-1:0]  b_mask;
      ubrk_cycle_t        b_cyc;
      logic [DATA_W-1:0]  b_data;
      logic [DATA_W-1:0]  b_dmask;
      logic               b_den;
      logic [ADDRESS_SPACE_ID_W-1:0]  b_address_space_id;
      logic               address_space_id_en;
      logic               seq;
      logic               a_post;
      logic               b_post;
      logic               cnt_en;
      logic [COUNT_W-1:0] count;
      logic               a_armed;
      logic               post_pend;
      logic               break_pre;
      logic               break_post;
      logic               fetch_exc;
      logic               operand_exc;
      logic               a_flag;
      logic               b_flag;
   } ubrk_state_t;

   ubrk_state_t state;
   ubrk_state_t next_state;

   ubrk_chan_if chan_a_cfg ();
   ubrk_chan_if chan_b_cfg ();

   logic a_hit;
   logic b_hit;

   // channel a has no data compare
   assign chan_a_cfg.cmp_addr  = state.a_addr;
   assign chan_a_cfg.addr_mask = state.a_mask;
   assign chan_a_cfg.cyc       = state.a_cyc;
   assign chan_a_cfg.cmp_data  = '0;
   assign chan_a_cfg.data_mask = '1;
   assign chan_a_cfg.data_en   = 1'b0;
   assign chan_a_cfg.space_id  = state.a_address_space_id;
   assign chan_a_cfg.address_space_id_en   = state.address_space_id_en;
   assign chan_b_cfg.cmp_addr  = state.b_addr;
   assign chan_b_cfg.addr_mask = state.b_mask;
   assign chan_b_cfg.cyc       = state.b_cyc;
   assign chan_b_cfg.cmp_data  = state.b_data;
   assign chan_b_cfg.data_mask = state.b_dmask;
   assign chan_b_cfg.data_en   = state.b_den;
   assign chan_b_cfg.space_id  = state.b_address_space_id;
   assign chan_b_cfg.address_space_id_en   = state.address_space_id_en;

   ubrk_pkg::ubrk_bus_t a_bus;
   ubrk_pkg::ubrk_bus_t b_bus;

   // each channel looks at exactly one master's cycles
   assign a_bus = state.a_cyc.dma_not_cpu ? dma_bus : cpu_bus;
   assign b_bus = state.b_cyc.dma_not_cpu ? dma_bus : cpu_bus;

   ubrk_chan_cmp u_cmp_a (
      .cfg (chan_a_cfg.cmp),
      .bus (a_bus),
      .hit (a_hit)
   );

   ubrk_chan_cmp u_cmp_b (
      .cfg (chan_b_cfg.cmp),
      .bus (b_bus),
      .hit (b_hit)
   );

   logic b_counted;
   logic b_eff;
   logic a_pre_hit;
   logic b_pre_hit;
   logic a_post_hit;
   logic b_post_hit;
   logic pre_req;
   logic post_req;
   logic seq_done;

   always_comb begin
      next_state = state;
      // execution count: no break until the count is down to one, then every matching execution breaks
      b_counted = b_hit;
      if (state.cnt_en && b_hit) begin
         b_counted = (state.count <= COUNT_ONE);
      end
      // sequence uses armed state from earlier cycles only
      seq_done = state.a_armed && b_counted;
      b_eff    = state.seq ? seq_done : b_counted;
      a_pre_hit  = a_hit && !state.a_post && !state.seq;
      a_post_hit = a_hit && state.a_post && !state.seq;
      b_pre_hit  = b_eff && !state.b_post;
      b_post_hit = b_eff && state.b_post;
      // pre-execution fetch break on a with simultaneous b still breaks
      if (state.seq && a_hit && b_hit && !state.a_post
          && state.a_cyc.ida == UBRK_ID_FETCH) begin
         a_pre_hit = 1'b1;
      end
      pre_req  = a_pre_hit || b_pre_hit;
      post_req = a_post_hit || b_post_hit || state.post_pend;

      if (state.seq && a_hit) begin
         next_state.a_armed = 1'b1;
      end
      if (seq_done) begin
         next_state.a_armed = 1'b0;
      end
      if (state.cnt_en && b_hit && state.count > COUNT_ONE) begin
         next_state.count = state.count - COUNT_ONE;
      end

      // fetch exception wins over the break; pre break wins over operand
      next_state.fetch_exc   = fetch_exception;
      next_state.break_pre   = pre_req && !fetch_exception;
      next_state.operand_exc = operand_exception && !fetch_exception && !pre_req;
      // post break waits for the instruction to retire; any operand fault drops it
      next_state.post_pend  = post_req && !insn_retire;
      next_state.break_post = post_req && insn_retire && !operand_exception
                              && !fetch_exception && !pre_req;
      if (post_req && operand_exception) begin
         next_state.post_pend = 1'b0;
      end

      // sticky flags: a new hit wins over the clear
      if (flag_clear) begin
         next_state.a_flag = 1'b0;
         next_state.b_flag = 1'b0;
      end
      if (a_hit && (!state.seq || a_pre_hit)) begin
         next_state.a_flag = 1'b1;
      end
      if (b_eff || (state.seq && a_pre_hit && b_hit)) begin
         next_state.b_flag = 1'b1;
      end

      // writes land at the memory-access stage, so the fetch already in
      // this cycle is judged against the old values
      if (cfg_write && cfg_from_cpu) begin
         next_state.a_addr  = chan_a_compare_address;
         next_state.a_mask  = chan_a_address_mask;
         next_state.a_cyc   = chan_a_cycle_select;
         next_state.a_address_space_id  = chan_a_space_id;
         next_state.b_addr  = chan_b_compare_address;
         next_state.b_mask  = chan_b_address_mask;
         next_state.b_cyc   = chan_b_cycle_select;
         next_state.b_data  = chan_b_compare_data;
         next_state.b_dmask = chan_b_data_mask;
         next_state.b_den   = chan_b_data_enable;
         next_state.b_address_space_id  = chan_b_space_id;
         next_state.address_space_id_en = address_space_id_check_enable;
         next_state.seq     = sequential_mode_bit;
         next_state.a_post  = chan_a_after_exec_select;
         next_state.b_post  = chan_b_after_exec_select;
         next_state.cnt_en  = count_enable;
         next_state.count   = execution_count_target;
         next_state.a_armed = 1'b0;
         next_state.post_pend = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state <= '0;
         state.count <= COUNT_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign break_pre         = state.break_pre;
   assign break_post        = state.break_post;
   assign take_fetch_exc    = state.fetch_exc;
   assign take_operand_exc  = state.operand_exc;
   assign chan_a_match_flag = state.a_flag;
   assign chan_b_match_flag = state.b_flag;
   assign count_remaining   = state.count;
endmodule : ubrk_top

// file: test/ubrk_pipe_model.sv
/*
 pipeline and dma bus model: presents one bus cycle per call of cyc.
 assumes one bench process calls cyc and samples outputs after it returns.
*/
`timescale 1ns/1ps
module ubrk_pipe_model
   import ubrk_pkg::*;
(
   input  wire logic sys_clk,
   output ubrk_bus_t  cpu_bus,
   output ubrk_bus_t  dma_bus,
   output logic       insn_retire,
   output logic       fetch_exception,
   output logic       operand_exception
);
   // no trace reads are modelled, so no branch can follow one
   initial begin
      cpu_bus = '0;
      dma_bus = '0;
      {insn_retire, fetch_exception, operand_exception} = 3'h0;
   end

   // cycles go out strictly in call order, each valid for one clock, one every two clocks
   task automatic cyc(input ubrk_bus_t c, input ubrk_bus_t d, input logic [2:0] ev);
      @(posedge sys_clk);
      cpu_bus <= c;
      dma_bus <= d;
      {insn_retire, fetch_exception, operand_exception} <= ev;
      @(posedge sys_clk);
      // released bus shows the inverse, never a stale copy of the cycle
      cpu_bus <= {1'b0, ~c[76:0]};
      dma_bus <= {1'b0, ~d[76:0]};
      {insn_retire, fetch_exception, operand_exception} <= 3'h0;
      #1;
   endtask : cyc
endmodule : ubrk_pipe_model

// file: test/ubrk_top_monitor.sv
/*
 concurrent checks on the breakpoint comparator ports.
 assumes binding to ubrk_top; single clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
module ubrk_top_monitor (
   input wire logic                         sys_clk,
   input wire logic                         reset_n,
   input wire logic                         cfg_write,
   input wire logic                         flag_clear,
   input ubrk_pkg::ubrk_bus_t               cpu_bus,
   input ubrk_pkg::ubrk_bus_t               dma_bus,
   input wire logic                         insn_retire,
   input wire logic                         fetch_exception,
   input wire logic                         operand_exception,
   input wire logic                         break_pre,
   input wire logic                         break_post,
   input wire logic                         take_fetch_exc,
   input wire logic                         take_operand_exc,
   input wire logic                         chan_a_match_flag,
   input wire logic [ubrk_pkg::COUNT_W-1:0] count_remaining
);
   import ubrk_pkg::*;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   a_fetch_exc_first: assert property (fetch_exception |=> take_fetch_exc && !break_pre)
      else $error("break taken over fetch exception");
   a_pre_before_operand: assert property (break_pre |-> !take_operand_exc)
      else $error("operand exception beside pre break");
   a_operand_taken: assert property (operand_exception && !fetch_exception |=>
      take_operand_exc || break_pre)
      else $error("operand exception lost");
   a_operand_before_post: assert property (operand_exception && insn_retire |=> !break_post)
      else $error("post break beside operand exception");
   a_post_on_retire: assert property (break_post |-> $past(insn_retire))
      else $error("post break without retire");
   a_dma_no_fetch: assert property (dma_bus.valid && dma_bus.fetch && !cpu_bus.valid |=>
      !break_pre)
      else $error("break from dma fetch");
   a_idle_no_break: assert property (!cpu_bus.valid && !dma_bus.valid |=> !break_pre)
      else $error("break without bus cycle");
   a_flag_holds: assert property (chan_a_match_flag && !flag_clear |=> chan_a_match_flag)
      else $error("match flag dropped");
   a_count_cause: assert property ($changed(count_remaining) |->
      $past(cfg_write) || $past(cpu_bus.valid) || $past(dma_bus.valid))
      else $error("count moved without cause");

   c_pre: cover property (break_pre);
   c_post: cover property (break_post);
   c_operand: cover property (take_operand_exc);
endmodule : ubrk_top_monitor

bind ubrk_top ubrk_top_monitor u_mon (.sys_clk(sys_clk), .reset_n(reset_n),
   .cfg_write(cfg_write), .flag_clear(flag_clear), .cpu_bus(cpu_bus), .dma_bus(dma_bus),
   .insn_retire(insn_retire), .fetch_exception(fetch_exception),
   .operand_exception(operand_exception), .break_pre(break_pre), .break_post(break_post),
   .take_fetch_exc(take_fetch_exc), .take_operand_exc(take_operand_exc),
   .chan_a_match_flag(chan_a_match_flag), .count_remaining(count_remaining));

// file: test/ubrk_top_tb.sv
/*
 self-checking bench for the breakpoint comparator: settings writes and bus
 cycles with expected outputs. assumes ubrk_pipe_model drives the bus side.
*/
`timescale 1ns/1ps
module ubrk_top_tb;
   import ubrk_pkg::*;
   localparam ubrk_cycle_t OFF = '0;
   localparam ubrk_cycle_t FRD = '{1'b0, UBRK_ID_FETCH, UBRK_RW_READ, UBRK_SZ_ANY};
   localparam ubrk_cycle_t FWR = '{1'b0, UBRK_ID_FETCH, UBRK_RW_WRITE, UBRK_SZ_WORD};
   localparam ubrk_cycle_t DRD = '{1'b0, UBRK_ID_DATA, UBRK_RW_READ, UBRK_SZ_ANY};
   localparam ubrk_cycle_t MFT = '{1'b1, UBRK_ID_FETCH, UBRK_RW_READ, UBRK_SZ_ANY};
   localparam ubrk_cycle_t MWB = '{1'b1, UBRK_ID_DATA, UBRK_RW_WRITE, UBRK_SZ_BYTE};
   localparam ubrk_bus_t   NB  = '0;
   logic              sys_clk, reset_n, cfg_write, cfg_from_cpu, flag_clear;
   logic [31:0]       a_addr, a_mask, b_addr, b_mask;
   ubrk_cycle_t       a_sel, b_sel;
   logic              d_en, id_en, seq, a_post, b_post, cnt_en;
   ubrk_bus_t         cpu_bus, dma_bus;
   logic              retire, f_exc, o_exc;
   logic              bp, bq, tf, to, fa, fb;
   logic [11:0]       count_remaining;
   logic [11:0]       o;
   int                checks = 0;
   int                failures = 0;
   logic [31:0]       ra[4] = '{32'h800e, 32'h8010, 32'h8016, 32'h8018};
   logic [11:0]       re[4] = '{12'h00, 12'h21, 12'h21, 12'h01};
   assign o = {6'h0, bp, bq, tf, to, fa, fb};

   ubrk_top dut (.sys_clk(sys_clk), .reset_n(reset_n), .cfg_write(cfg_write),
      .cfg_from_cpu(cfg_from_cpu), .chan_a_compare_address(a_addr),
      .chan_a_address_mask(a_mask), .chan_a_cycle_select(a_sel), .chan_a_space_id(8'h80),
      .chan_b_compare_address(b_addr), .chan_b_address_mask(b_mask),
      .chan_b_cycle_select(b_sel), .chan_b_compare_data(32'h78), .chan_b_data_mask(32'hf),
      .chan_b_data_enable(d_en), .chan_b_space_id(8'h70), .address_space_id_check_enable(id_en),
      .sequential_mode_bit(seq), .chan_a_after_exec_select(a_post),
      .chan_b_after_exec_select(b_post), .count_enable(cnt_en),
      .execution_count_target(12'h005), .flag_clear(flag_clear), .cpu_bus(cpu_bus),
      .dma_bus(dma_bus), .insn_retire(retire), .fetch_exception(f_exc),
      .operand_exception(o_exc), .break_pre(bp), .break_post(bq), .take_fetch_exc(tf),
      .take_operand_exc(to), .chan_a_match_flag(fa), .chan_b_match_flag(fb),
      .count_remaining(count_remaining));
   ubrk_pipe_model pm (.sys_clk(sys_clk), .cpu_bus(cpu_bus), .dma_bus(dma_bus),
      .insn_retire(retire), .fetch_exception(f_exc), .operand_exception(o_exc));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   function automatic ubrk_bus_t bc(input logic m, input logic f, input logic w,
      input ubrk_sz_t s, input logic [31:0] a, input logic [31:0] d, input logic [7:0] id);
      bc = '{1'b1, m, f, w, s, a, d, id};
   endfunction : bc

   function automatic ubrk_bus_t fe(input logic [31:0] a, input logic [7:0] id);
      fe = bc(1'b0, 1'b1, 1'b0, UBRK_SZ_WORD, a, 32'h0, id);
   endfunction : fe

   // m = {from_cpu, data_en, address_space_id_en, seq, a_post, b_post, cnt_en, flag_clear}
   task automatic cfg(input ubrk_cycle_t sa, input ubrk_cycle_t sb, input logic [31:0] aa,
      input logic [31:0] ma, input logic [31:0] ab, input logic [31:0] mb, input logic [7:0] m);
      @(posedge sys_clk);
      {a_sel, b_sel, a_addr, a_mask, b_addr, b_mask} <= {sa, sb, aa, ma, ab, mb};
      {cfg_from_cpu, d_en, id_en, seq, a_post, b_post, cnt_en, flag_clear} <= m;
      cfg_write <= 1'b1;
      @(posedge sys_clk);
      cfg_write <= 1'b0;
      flag_clear <= 1'b0;
      // settings are in force before any later cycle or compare
      #1;
   endtask : cfg

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic summarize;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : summarize

   initial begin
      {reset_n, cfg_write, cfg_from_cpu, flag_clear, d_en, id_en, seq} = '0;
      {a_post, b_post, cnt_en, a_addr, a_mask, b_addr, b_mask, a_sel, b_sel} = '0;
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      cfg(OFF, FRD, 32'h0, 32'h0, 32'h8010, 32'h6, 8'h81);
      for (int i = 0; i < 4; i++) begin
         pm.cyc(fe(ra[i], 8'h0), NB, 3'h0);
         chk(o, re[i]);
      end
      $display("test masked address done");
      // bit 0 masked on b, so only the odd compare address can block the hit
      cfg(FWR, FRD, 32'h27128, 32'h0, 32'h31415, 32'h1, 8'h81);
      pm.cyc(fe(32'h27128, 8'h0), NB, 3'h0);
      chk(o, 12'h00);
      pm.cyc(fe(32'h31414, 8'h0), NB, 3'h0);
      chk(o, 12'h00);
      $display("test impossible fetch done");
      cfg(OFF, FRD, 32'h0, 32'h0, 32'h1000, 32'h0, 8'h83);
      chk(count_remaining, 12'h005);
      for (int i = 4; i > 0; i--) begin
         pm.cyc(fe(32'h1000, 8'h0), NB, 3'h0);
         chk(o & 12'h20, 12'h00);
         chk(count_remaining, 12'(i));
      end
      pm.cyc(fe(32'h1000, 8'h0), NB, 3'h0);
      chk(o & 12'h20, 12'h20);
      $display("test execution count done");
      cfg(DRD, OFF, 32'h123456, 32'h0, 32'h0, 32'h0, 8'h81);
      pm.cyc(bc(1'b0, 1'b0, 1'b0, UBRK_SZ_LONG, 32'h123454, 32'h0, 8'h0), NB, 3'h0);
      chk(o, 12'h22);
      pm.cyc(bc(1'b0, 1'b0, 1'b0, UBRK_SZ_WORD, 32'h123456, 32'h0, 8'h0), NB, 3'h0);
      chk(o, 12'h22);
      pm.cyc(bc(1'b0, 1'b0, 1'b0, UBRK_SZ_BYTE, 32'h123457, 32'h0, 8'h0), NB, 3'h0);
      chk(o, 12'h02);
      $display("test access size done");
      cfg(MFT, MWB, 32'h314156, 32'h0, 32'h55555, 32'h0, 8'hc1);
      pm.cyc(NB, bc(1'b1, 1'b1, 1'b0, UBRK_SZ_LONG, 32'h314156, 32'h0, 8'h0), 3'h0);
      chk(o, 12'h00);
      pm.cyc(NB, bc(1'b1, 1'b0, 1'b1, UBRK_SZ_BYTE, 32'h55555, 32'h7a, 8'h0), 3'h0);
      chk(o, 12'h21);
      pm.cyc(NB, bc(1'b1, 1'b0, 1'b1, UBRK_SZ_BYTE, 32'h55555, 32'h68, 8'h0), 3'h0);
      chk(o, 12'h01);
      pm.cyc(bc(1'b0, 1'b0, 1'b1, UBRK_SZ_BYTE, 32'h55555, 32'h7a, 8'h0), NB, 3'h0);
      chk(o, 12'h01);
      $display("test dma data done");
      cfg(FRD, OFF, 32'h37226, 32'h0, 32'h0, 32'h0, 8'ha1);
      pm.cyc(fe(32'h37226, 8'h70), NB, 3'h0);
      chk(o, 12'h00);
      pm.cyc(fe(32'h37226, 8'h80), NB, 3'h0);
      chk(o, 12'h22);
      cfg(OFF, FRD, 32'h0, 32'h0, 32'h8010, 32'h0, 8'h01);
      pm.cyc(fe(32'h37226, 8'h80), NB, 3'h0);
      chk(o, 12'h22);
      $display("test space id done");
      cfg(FRD, FRD, 32'h37226, 32'h0, 32'h3722e, 32'h0, 8'h91);
      pm.cyc(fe(32'h3722e, 8'h0), NB, 3'h0);
      chk(o & 12'h20, 12'h00);
      pm.cyc(fe(32'h37226, 8'h0), NB, 3'h0);
      chk(o & 12'h20, 12'h00);
      pm.cyc(fe(32'h3722e, 8'h0), NB, 3'h0);
      chk(o & 12'h20, 12'h20);
      cfg(DRD, DRD, 32'h2000, 32'h0, 32'h2000, 32'h0, 8'h91);
      pm.cyc(bc(1'b0, 1'b0, 1'b0, UBRK_SZ_WORD, 32'h2000, 32'h0, 8'h0), NB, 3'h0);
      chk(o & 12'h20, 12'h00);
      cfg(FRD, FRD, 32'h37226, 32'h0, 32'h37226, 32'h0, 8'h91);
      pm.cyc(fe(32'h37226, 8'h0), NB, 3'h0);
      chk(o, 12'h23);
      $display("test sequence done");
      cfg(FRD, OFF, 32'h500, 32'h0, 32'h0, 32'h0, 8'h81);
      pm.cyc(fe(32'h500, 8'h0), NB, 3'h2);
      chk(o & 12'h2c, 12'h08);
      pm.cyc(fe(32'h500, 8'h0), NB, 3'h1);
      chk(o & 12'h2c, 12'h20);
      cfg(FRD, OFF, 32'h404, 32'h0, 32'h0, 32'h0, 8'h89);
      pm.cyc(fe(32'h404, 8'h0), NB, 3'h0);
      chk(o & 12'h30, 12'h00);
      pm.cyc(NB, NB, 3'h4);
      chk(o & 12'h30, 12'h10);
      pm.cyc(fe(32'h404, 8'h0), NB, 3'h0);
      pm.cyc(NB, NB, 3'h5);
      chk(o & 12'h14, 12'h04);
      $display("test priority done");
      summarize();
   end
endmodule : ubrk_top_tb
